// File: design/standby_defines.svh
// register offsets, field positions, reset values and timing counts for the standby controller
// assumes a 32-bit apb slave with one aligned word per register
`ifndef STANDBY_DEFINES_SVH
`define STANDBY_DEFINES_SVH
`define SYS_CTRL_ONE_ADDR 12'h038
`define SYS_CTRL_TWO_ADDR 12'h03C
`define STATUS_ADDR 12'h040
`define BIT_STOP_START 7
`define BIT_RELEASE_METHOD 6
`define BIT_PORT_HOLD 4
`define WARMUP_HI 3
`define WARMUP_LO 2
`define BIT_OSC_ENABLE 7
`define BIT_CPU_IDLE 4
`define BIT_TIMING_HALT 2
`define SYS_CTRL_ONE_RESET 8'h00
`define SYS_CTRL_TWO_RESET 8'h80
`define WARMUP_CNT_00 21'h030000
`define WARMUP_CNT_01 21'h010000
`define WARMUP_CNT_10 21'h00C000
`define WARMUP_CNT_11 21'h004000
`define DIVIDER_WIDTH 21
`endif

// File: design/standby_pkg.sv
// types shared by the standby controller and its bench
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package standby_pkg;
  // operating mode of the block
  typedef enum logic [2:0] {
    normal_run_mode,
    cpu_idle_mode,
    clock_gated_idle_mode,
    stop_mode,
    warmup_mode
  } mode_t;
  // apb request bundle from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  // apb answer bundle to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  // control strobes towards the rest of the chip
  typedef struct packed {
    logic osc_run;
    logic cpu_halt;
    logic wdt_halt;
    logic periph_halt;
    logic tg_clear;
    logic port_hiz;
    logic port_in_force_zero;
    logic wake_pin_hiz;
    logic chip_reset_req;
    logic resume_pulse;
  } ctrl_t;
endpackage
`default_nettype wire

// File: design/standby_mode_controller.sv
// standby controller: stop, cpu idle and clock-gated idle entry and release
// assumes wake pin, reset pin and base-timer clock are asynchronous; the cpu keeps its pc while halted
`default_nettype none
`include "standby_defines.svh"
// Contract
// - stop-start bit enters oscillator-off stop
// - release bit picks edge or level wake
// - level mode: wake pin high releases
// - level mode: pin high skips stop, still warms up
// - stopped ports hiz or hold by bit
// - hold bit zero forces inputs zero
// - wake pin goes hiz in stop
// - warmup field picks four cycle counts
// - release restarts oscillator, warms up, resumes
// - divider counts warmup on basic clock
// - prescaler and divider cleared on stop
// - memory, registers, latches kept in stop
// - pc holds stop instruction plus two
// - reset pin low ends stop normally
// - clearing oscillator enable resets device
// - cpu idle bit halts cpu, self-clears
// - timing halt bit idles, self-clears
// - some bits read back undefined
// - gated idle may end early, asynchronous; here only a synchronised base clock fall ends it
// - gated idle ends on base clock fall
// - cpu idle ends on enabled interrupt
module standby_mode_controller
  (
  input wire logic pclk,
  input wire logic presetn,
  input wire standby_pkg::apb_req_t apb_req,
  output standby_pkg::apb_rsp_t apb_rsp,
  input wire logic wake_port_pin,
  input wire logic base_timer_clock,
  input wire logic enabled_irq_pending,
  output standby_pkg::ctrl_t ctrl,
  output logic [2:0] mode_out,
  output logic [20:0] tg_divider_out
  );
  import standby_pkg::*;

  // synchronisers for the asynchronous inputs
  logic wake_meta_q, wake_sync_q, wake_prev_q;
  logic btc_meta_q, btc_sync_q, btc_prev_q;
  // the two control registers
  logic [7:0] sys_ctrl_one_q;
  logic [7:0] sys_ctrl_two_q;
  // mode and the timing generator divider
  mode_t mode_q;
  logic [`DIVIDER_WIDTH-1:0] divider_q;
  logic [`DIVIDER_WIDTH-1:0] warmup_target;
  // registered answer and control outputs
  apb_rsp_t rsp_q;
  ctrl_t ctrl_q;
  // bus decode helpers plus wake level and wake/base-clock edge helpers
  logic access_phase, wr_en, rd_en;
  logic stop_write, wake_level, wake_rise, btc_fall;

  // warmup length from the two-bit field
  function automatic logic [`DIVIDER_WIDTH-1:0] warmup_count(input logic [1:0] sel);
    case (sel)
      2'h0: warmup_count = `WARMUP_CNT_00;
      2'h1: warmup_count = `WARMUP_CNT_01;
      2'h2: warmup_count = `WARMUP_CNT_10;
      default: warmup_count = `WARMUP_CNT_11;
    endcase
  endfunction

  // address match, used by both write and read paths
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] b);
    addr_is = (a[11:2] == b[11:2]);
  endfunction

  assign access_phase = apb_req.psel & apb_req.penable;
  assign wr_en = access_phase & apb_req.pwrite;
  assign rd_en = access_phase & ~apb_req.pwrite;
  assign stop_write = wr_en & addr_is(apb_req.paddr, `SYS_CTRL_ONE_ADDR)
    & apb_req.pwdata[`BIT_STOP_START] & (mode_q == normal_run_mode);
  assign wake_level = wake_sync_q;
  assign wake_rise = wake_sync_q & ~wake_prev_q;
  assign btc_fall = ~btc_sync_q & btc_prev_q;
  assign warmup_target = warmup_count(sys_ctrl_one_q[`WARMUP_HI:`WARMUP_LO]);

  // two-flop synchronisers plus an edge flop; the second stage and the edge flop are looked at, never the first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
      wake_prev_q <= 1'b0;
      btc_meta_q <= 1'b0;
      btc_sync_q <= 1'b0;
      btc_prev_q <= 1'b0;
    end
    else
    begin
      wake_meta_q <= wake_port_pin;
      wake_sync_q <= wake_meta_q;
      wake_prev_q <= wake_sync_q;
      btc_meta_q <= base_timer_clock;
      btc_sync_q <= btc_meta_q;
      btc_prev_q <= btc_sync_q;
    end
  end

  // first control register; stop-start self-clears on return to run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys_ctrl_one_q <= `SYS_CTRL_ONE_RESET;
    else if (wr_en && addr_is(apb_req.paddr, `SYS_CTRL_ONE_ADDR) && mode_q == normal_run_mode)
      sys_ctrl_one_q <= {apb_req.pwdata[7:6], 1'b0, apb_req.pwdata[4:2], 2'b00};
    else if (mode_q == warmup_mode && divider_q >= warmup_target - 1'b1)
      sys_ctrl_one_q[`BIT_STOP_START] <= 1'b0;
  end

  // second control register; idle bits cleared by hardware on release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys_ctrl_two_q <= `SYS_CTRL_TWO_RESET;
    else if (wr_en && addr_is(apb_req.paddr, `SYS_CTRL_TWO_ADDR) && mode_q == normal_run_mode)
      sys_ctrl_two_q <= {apb_req.pwdata[7], 2'b00, apb_req.pwdata[4], 1'b0, apb_req.pwdata[2], 2'b00};
    else if (mode_q == cpu_idle_mode && enabled_irq_pending)
      sys_ctrl_two_q[`BIT_CPU_IDLE] <= 1'b0;
    else if (mode_q == clock_gated_idle_mode && btc_fall)
      sys_ctrl_two_q[`BIT_TIMING_HALT] <= 1'b0;
  end

  // mode sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= normal_run_mode;
    else
    begin
      case (mode_q)
        normal_run_mode:
        begin
          if (stop_write)
          begin
            // level mode with pin already high skips the oscillator stop
            if (apb_req.pwdata[`BIT_RELEASE_METHOD] && wake_level)
              mode_q <= warmup_mode;
            else
              mode_q <= stop_mode;
          end
          else if (wr_en && addr_is(apb_req.paddr, `SYS_CTRL_TWO_ADDR) && apb_req.pwdata[`BIT_CPU_IDLE])
            mode_q <= cpu_idle_mode;
          else if (wr_en && addr_is(apb_req.paddr, `SYS_CTRL_TWO_ADDR) && apb_req.pwdata[`BIT_TIMING_HALT])
            mode_q <= clock_gated_idle_mode;
        end
        stop_mode:
        begin
          // both wake paths; the edge path only on a fresh rise
          if (sys_ctrl_one_q[`BIT_RELEASE_METHOD] ? wake_level : wake_rise)
            mode_q <= warmup_mode;
        end
        warmup_mode:
        begin
          if (divider_q >= warmup_target - 1'b1)
            mode_q <= normal_run_mode;
        end
        cpu_idle_mode:
        begin
          if (enabled_irq_pending)
            mode_q <= normal_run_mode;
        end
        clock_gated_idle_mode:
        begin
          if (btc_fall)
            mode_q <= normal_run_mode;
        end
        default: mode_q <= normal_run_mode;
      endcase
    end
  end

  // timing generator divider: cleared on stop, counts the warmup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divider_q <= '0;
    else if (stop_write || mode_q == stop_mode)
      divider_q <= '0;
    else if (mode_q == warmup_mode && divider_q >= warmup_target - 1'b1)
      divider_q <= '0;
    else
      divider_q <= divider_q + 1'b1;
  end

  // chip-level control strobes, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= '0;
    else
    begin
      ctrl_q.osc_run <= (mode_q != stop_mode);
      ctrl_q.cpu_halt <= (mode_q != normal_run_mode);
      ctrl_q.wdt_halt <= (mode_q != normal_run_mode);
      ctrl_q.periph_halt <= (mode_q == stop_mode) || (mode_q == warmup_mode)
        || (mode_q == clock_gated_idle_mode);
      ctrl_q.tg_clear <= (mode_q == stop_mode);
      ctrl_q.port_hiz <= (mode_q == stop_mode) && !sys_ctrl_one_q[`BIT_PORT_HOLD];
      ctrl_q.port_in_force_zero <= (mode_q == stop_mode) && !sys_ctrl_one_q[`BIT_PORT_HOLD];
      ctrl_q.wake_pin_hiz <= (mode_q == stop_mode);
      ctrl_q.chip_reset_req <= !sys_ctrl_two_q[`BIT_OSC_ENABLE];
      ctrl_q.resume_pulse <= (mode_q != normal_run_mode) && (mode_q != stop_mode)
        && ((mode_q == warmup_mode) ? (divider_q >= warmup_target - 1'b1)
        : (mode_q == cpu_idle_mode) ? enabled_irq_pending : btc_fall);
    end
  end

  // apb answer: one wait-free access phase, error on unmapped word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsp_q <= '0;
    else
    begin
      rsp_q.pready <= apb_req.psel & ~apb_req.penable;
      rsp_q.pslverr <= apb_req.psel & ~apb_req.penable
        & ~(addr_is(apb_req.paddr, `SYS_CTRL_ONE_ADDR) | addr_is(apb_req.paddr, `SYS_CTRL_TWO_ADDR)
        | addr_is(apb_req.paddr, `STATUS_ADDR));
      if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      begin
        // undefined bits read as zero here
        if (addr_is(apb_req.paddr, `SYS_CTRL_ONE_ADDR))
          rsp_q.prdata <= {24'h000000, sys_ctrl_one_q[7:2], 2'b00};
        else if (addr_is(apb_req.paddr, `SYS_CTRL_TWO_ADDR))
          rsp_q.prdata <= {24'h000000, sys_ctrl_two_q[7:4], 1'b0, sys_ctrl_two_q[2], 2'b00};
        else if (addr_is(apb_req.paddr, `STATUS_ADDR))
          rsp_q.prdata <= {29'h00000000, mode_q};
        else
          rsp_q.prdata <= 32'h00000000;
      end
      else if (rd_en)
        rsp_q.prdata <= rsp_q.prdata;
    end
  end

  // mirrors for observation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_out <= 3'h0;
      tg_divider_out <= 21'h000000;
    end
    else
    begin
      mode_out <= mode_q;
      tg_divider_out <= divider_q;
    end
  end

  assign apb_rsp = rsp_q;
  assign ctrl = ctrl_q;
endmodule
`default_nettype wire

// File: sim/standby_mode_controller_checker.sv
// checker: mode, divider and strobe relations at the controller ports
// assumes the design's zero-wait apb and the mode encoding of its package
`default_nettype none
module standby_mode_controller_checker
  import standby_pkg::*;
  (
  input wire logic pclk,
  input wire logic presetn,
  input wire standby_pkg::apb_req_t apb_req,
  input wire standby_pkg::apb_rsp_t apb_rsp,
  input wire logic wake_port_pin,
  input wire logic base_timer_clock,
  input wire logic enabled_irq_pending,
  input wire standby_pkg::ctrl_t ctrl,
  input wire logic [2:0] mode_out,
  input wire logic [20:0] tg_divider_out
  );
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [20:0] wcnt_q; // cycles spent warming up
  logic [20:0] wcnt_d;
  // counts warmup length independently of the divider output
  assign wcnt_d = (mode_out == 3'h4) ? wcnt_q + 21'h000001 : 21'h000000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wcnt_q <= 21'h000000;
    else
      wcnt_q <= wcnt_d;
  end
  chk_stop_halts_all: assert property (
    mode_out == 3'h3 |-> !ctrl.osc_run && ctrl.cpu_halt && ctrl.periph_halt) else $error("stop not halting");
  chk_stop_div_zero: assert property (
    mode_out == 3'h3 |-> tg_divider_out == 21'h000000) else $error("divider not cleared");
  chk_wake_pin_hiz: assert property (
    mode_out == 3'h3 |-> ctrl.wake_pin_hiz) else $error("wake pin driven in stop");
  chk_port_hiz_zero: assert property (
    mode_out == 3'h3 |-> ctrl.port_hiz == ctrl.port_in_force_zero) else $error("input force mismatch");
  chk_warmup_halted: assert property (
    mode_out == 3'h4 |-> ctrl.osc_run && ctrl.cpu_halt) else $error("warmup not halted");
  chk_warmup_length: assert property (
    mode_out == 3'h4 ##1 mode_out == 3'h0 |-> $past(wcnt_q) inside {[21'h003FFE:21'h004000],
    [21'h00BFFE:21'h00C000], [21'h00FFFE:21'h010000], [21'h02FFFE:21'h030000]}) else $error("warmup length");
  chk_idle_release: assert property (
    mode_out == 3'h1 && enabled_irq_pending |-> ##[1:4] mode_out == 3'h0) else $error("cpu idle kept");
  chk_cpu_idle_halt: assert property (
    mode_out == 3'h1 |-> ctrl.cpu_halt && ctrl.wdt_halt && ctrl.osc_run) else $error("cpu idle halt");
  chk_apb_ready: assert property (
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready) else $error("no pready");
  cov_stop: cover property (mode_out == 3'h3 ##1 mode_out == 3'h4);
  cov_gated: cover property (mode_out == 3'h2 ##1 mode_out == 3'h0);
  cov_idle: cover property (mode_out == 3'h1 ##1 mode_out == 3'h0);
endmodule
`default_nettype wire

// File: sim/standby_far_side.sv
// far side: wake pin source and base-timer clock
// assumes the bench commands the levels; no pull on the wake line
`default_nettype none
module standby_far_side
  (
  input wire logic wake_cmd,
  input wire logic bt_run,
  output logic wake_port_pin,
  output logic base_timer_clock
  );
  timeunit 1ns;
  timeprecision 1ps;
  // bench commands level stop once with the pin low and once with it already high
  assign wake_port_pin = wake_cmd;
  // base clock stands still unless asked, so any fall is a real one
  initial base_timer_clock = 1'b1;
  always #10 base_timer_clock = bt_run ? ~base_timer_clock : base_timer_clock;
endmodule
`default_nettype wire

// File: sim/standby_mode_controller_bench.sv
// bench: register, stop, idle and reset scenarios for the standby controller
// assumes warmup select 11 keeps each release near 16384 cycles
`default_nettype none
`include "standby_defines.svh"
module standby_mode_controller_bench;
  import standby_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0; // 125 MHz
  logic presetn = 1'b0;
  logic wake_cmd = 1'b0;
  logic bt_run = 1'b0;
  logic irq = 1'b0;
  wire logic wake;
  wire logic btclk;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  ctrl_t ctrl;
  logic [2:0] mode;
  logic [20:0] div;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int comparisons = 0;
  int n;
  always #4 pclk = ~pclk;
  standby_mode_controller i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .wake_port_pin(wake), .base_timer_clock(btclk), .enabled_irq_pending(irq), .ctrl(ctrl),
    .mode_out(mode), .tg_divider_out(div));
  standby_far_side i_far (.wake_cmd(wake_cmd), .bt_run(bt_run), .wake_port_pin(wake), .base_timer_clock(btclk));
  // one comparison, tallied
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      begin
        failures++;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
  endtask
  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // bounded wait for a mode; n keeps the cycles taken
  task automatic wait_mode(input logic [2:0] m);
    n = 0;
    while (mode !== m && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(mode, m);
  endtask
  task automatic t_regs();
    apb(1'b0, `SYS_CTRL_ONE_ADDR, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, `SYS_CTRL_TWO_ADDR, 32'h0);
    chk(rd, 32'h00000080);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[30:0], err}, 32'h00000001);
    $display("regs done");
  endtask
  // edge release, ports released, warmup 11
  // no interrupts are raised around stop, so nothing to mask
  task automatic t_stop_edge();
    apb(1'b1, `SYS_CTRL_ONE_ADDR, 32'h0000008C);
    wait_mode(3'h3);
    chk({ctrl.port_hiz, ctrl.port_in_force_zero, ctrl.wake_pin_hiz, ctrl.osc_run}, 32'hE);
    chk(div, 32'h0);
    repeat (40) @(posedge pclk);
    chk(mode, 3'h3);
    wake_cmd <= 1'b1;
    wait_mode(3'h4);
    wait_mode(3'h0);
    chk(n >= 16380 && n <= 16388, 1'b1);
    apb(1'b0, `SYS_CTRL_ONE_ADDR, 32'h0);
    chk(rd, 32'h0000000C);
    wake_cmd <= 1'b0;
    $display("stop edge done");
  endtask
  // level release with ports held, then a request while the pin is high
  task automatic t_stop_level();
    apb(1'b1, `SYS_CTRL_ONE_ADDR, 32'h000000DC);
    wait_mode(3'h3);
    chk({ctrl.port_hiz, ctrl.wake_pin_hiz}, 32'h1);
    wake_cmd <= 1'b1;
    wait_mode(3'h4);
    wait_mode(3'h0);
    apb(1'b1, `SYS_CTRL_ONE_ADDR, 32'h000000CC);
    repeat (2) @(posedge pclk);
    chk({mode, ctrl.osc_run}, {3'h4, 1'b1});
    wait_mode(3'h0);
    wake_cmd <= 1'b0;
    $display("stop level done");
  endtask
  // idle bits written one at a time, spare bits zero
  task automatic t_idle();
    apb(1'b1, `SYS_CTRL_TWO_ADDR, 32'h00000090);
    wait_mode(3'h1);
    irq <= 1'b1;
    wait_mode(3'h0);
    irq <= 1'b0;
    apb(1'b0, `SYS_CTRL_TWO_ADDR, 32'h0);
    chk(rd, 32'h00000080);
    apb(1'b1, `SYS_CTRL_TWO_ADDR, 32'h00000084);
    wait_mode(3'h2);
    repeat (20) @(posedge pclk);
    chk(mode, 3'h2);
    bt_run <= 1'b1;
    wait_mode(3'h0);
    bt_run <= 1'b0;
    apb(1'b0, `SYS_CTRL_TWO_ADDR, 32'h0);
    chk(rd, 32'h00000080);
    $display("idle done");
  endtask
  // reset pin ends stop; clearing oscillator enable asks for a reset
  task automatic t_resets();
    apb(1'b1, `SYS_CTRL_ONE_ADDR, 32'h0000008C);
    wait_mode(3'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({mode, ctrl.osc_run}, {3'h0, 1'b1});
    apb(1'b1, `SYS_CTRL_TWO_ADDR, 32'h0);
    repeat (3) @(posedge pclk);
    chk(ctrl.chip_reset_req, 1'b1);
    $display("resets done");
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_stop_edge();
    t_stop_level();
    t_idle();
    t_resets();
    final_report();
  end
  // watchdog well beyond three warmups
  initial
  begin
    repeat (90000) @(posedge pclk);
    failures++;
    final_report();
  end
endmodule
bind standby_mode_controller standby_mode_controller_checker i_chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .wake_port_pin(wake_port_pin), .base_timer_clock(base_timer_clock),
  .enabled_irq_pending(enabled_irq_pending), .ctrl(ctrl), .mode_out(mode_out), .tg_divider_out(tg_divider_out));
`default_nettype wire
